/* File: hdl/lcr_regs_top.sv */
// Upper configuration register bank: calibration codes, spare words, write key, checksum
//
// Summary of operation
// RULE_01 - 24-bit signed offset code at 0x9, reset zero
// RULE_02 - 24-bit unsigned gain code at 0xA
// RULE_03 - Gain code resets to 800000, unity gain
// RULE_04 - Spare word 0xB resets 0x900000, host keeps it
// RULE_05 - Spare byte 0xC resets 0x50, host keeps it
// RULE_06 - Spare halfword 0xE resets to variant value
// RULE_07 - Key 0xA5, the default, opens every register
// RULE_08 - Unlocked: no checksum, checksum reads zero
// RULE_09 - Locked: only the key register is writable
// RULE_10 - Locked checksum advances only on modulator clock
// RULE_11 - Read-only 16-bit checksum at 0xF, reset zero
// RULE_12 - Commands obeyed only when address bits match
// RULE_13 - Offset code applied only when enable set
// RULE_14 - Checksum error flag low on mismatch, else high
// RULE_15 - Locked writes dropped silently, nothing else changes
// RULE_16 - Writing 0xA5 unlocks for following cycles
`timescale 1ns/1ps
`include "lcr_regs_cfg.svh"

module lcr_regs_top (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Serial port pins
   input wire logic spiCsN,
   input wire logic spiSck,
   input wire logic spiMosi,
   output logic spiMisoOut,
   output logic spiMisoOe,
   // Modulator data clock pin, sampled as a level
   input wire logic modulatorDataClock,
   // Configuration bit from the main configuration register
   input wire logic offsetCorrectionEnable,
   // Calibration codes towards the datapath
   output logic [23:0] offsetCorrectionCode,
   output logic [23:0] gainCorrectionCode,
   // Status
   output logic mapLocked,
   output logic configChecksumErrorFlag
);
   import lcr_regs_pkg::*;

   // Power-on contents of every state field
   localparam lcr_state_t RESET_STATE = '{
      cs1: 1'b1, cs2: 1'b1, cs3: 1'b1,
      sck1: 1'b0, sck2: 1'b0, sck3: 1'b0,
      mosi1: 1'b0, mosi2: 1'b0,
      dm1: 1'b0, dm2: 1'b0, dm3: 1'b0,
      spiState: LCR_IDLE,
      cmdType: 2'h0,
      regAddr: 4'h0,
      bitCnt: 5'h00,
      shiftIn: 24'h000000,
      shiftOut: 24'h000000,
      misoBit: 1'b0,
      misoEn: 1'b0,
      offsetTrim: `LCR_RST_OFFSET,
      gainTrim: `LCR_RST_GAIN,
      spareWordB: `LCR_RST_SPARE_B,
      spareByteC: `LCR_RST_SPARE_C,
      writeKey: `LCR_RST_KEY,
      spareHalfwordE: `LCR_RST_SPARE_E,
      mapChecksum: `LCR_RST_CHECKSUM,
      crcAcc: `LCR_CRC_SEED,
      crcIdx: 7'h00,
      refChecksum: 16'h0000,
      refValid: 1'b0,
      checksumOk: 1'b1,
      offsetApplied: 24'h000000
   };

   lcr_state_t q; // Registered state
   lcr_state_t d; // Next state

   logic locked; // Key differs from the unlock code
   logic csFall; // Chip select just went active
   logic sckRise; // Serial clock rising edge, sample point
   logic sckFall; // Serial clock falling edge, launch point
   logic dmRise; // Modulator clock rising edge
   logic [4:0] lastIdx; // Last bit index of the current unit
   logic [23:0] newWord; // Shift register including the bit now sampled
   logic [7:0] statusByte; // Byte returned during the command byte
   logic [3:0] nextAddr; // Register after the current one
   logic [`LCR_CFG_BITS-1:0] cfgVec; // Bits covered by the checksum
   logic crcBit; // Configuration bit fed this step
   logic [15:0] crcNext; // Remainder after this step

   // Last bit index of a register by its offset; unmapped offsets act as bytes
   function automatic logic [4:0] lastBitOf(input logic [3:0] a);
      logic [4:0] r;
      r = `LCR_LAST_8;
      if (a == `LCR_ADDR_OFFSET || a == `LCR_ADDR_GAIN || a == `LCR_ADDR_SPARE_B) begin
         r = `LCR_LAST_24;
      end else if (a == `LCR_ADDR_SPARE_E || a == `LCR_ADDR_CHECKSUM) begin
         r = `LCR_LAST_16;
      end
      return r;
   endfunction

   // Read value of a register, placed at the top of the 24-bit shifter
   function automatic logic [23:0] readAligned(input lcr_state_t s, input logic [3:0] a);
      logic [23:0] r;
      r = 24'h000000;
      unique case (a)
         `LCR_ADDR_OFFSET: r = s.offsetTrim;
         `LCR_ADDR_GAIN: r = s.gainTrim;
         `LCR_ADDR_SPARE_B: r = s.spareWordB;
         `LCR_ADDR_SPARE_C: r = {s.spareByteC, 16'h0000};
         `LCR_ADDR_KEY: r = {s.writeKey, 16'h0000};
         `LCR_ADDR_SPARE_E: r = {s.spareHalfwordE, 8'h00};
         `LCR_ADDR_CHECKSUM: r = {s.mapChecksum, 8'h00};
         default: r = 24'h000000; // Lower map lives elsewhere, reads zero here
      endcase
      return r;
   endfunction

   // Serial checksum step
   lcr_crc16_step crcStep (
      .crcIn(q.crcAcc),
      .dataBit(crcBit),
      .crcOut(crcNext)
   );

   // Next-state logic for the serial port, the registers and the checksum engine
   always_comb begin
      d = q;
      // Pins pass two flip-flops before anything reads them
      d.cs1 = spiCsN;
      d.cs2 = q.cs1;
      d.cs3 = q.cs2;
      d.sck1 = spiSck;
      d.sck2 = q.sck1;
      d.sck3 = q.sck2;
      d.mosi1 = spiMosi;
      d.mosi2 = q.mosi1;
      d.dm1 = modulatorDataClock;
      d.dm2 = q.dm1;
      d.dm3 = q.dm2;

      locked = (q.writeKey != `LCR_KEY_UNLOCK); // RULE_07
      csFall = q.cs3 & ~q.cs2;
      sckRise = q.sck2 & ~q.sck3;
      sckFall = q.sck3 & ~q.sck2;
      dmRise = q.dm2 & ~q.dm3;
      lastIdx = (q.spiState == LCR_CMD) ? `LCR_LAST_8 : lastBitOf(q.regAddr);
      newWord = {q.shiftIn[22:0], q.mosi2}; // RULE_01 RULE_02
      statusByte = {3'b000, `LCR_DEV_ADDR, q.checksumOk, 2'b11};
      nextAddr = q.regAddr + 4'h1;
      cfgVec = {q.offsetTrim, q.gainTrim, q.spareWordB, q.spareByteC,
                q.writeKey, q.spareHalfwordE};
      crcBit = cfgVec[(`LCR_CFG_BITS - 1) - q.crcIdx];

      // Serial port
      if (q.cs2) begin
         // Deselected: release the data line and forget the transfer
         d.spiState = LCR_IDLE;
         d.misoEn = 1'b0;
         d.bitCnt = 5'h00;
      end else if (csFall) begin
         // Status byte leaves MSB first while the command byte comes in
         d.spiState = LCR_CMD;
         d.bitCnt = 5'h00;
         d.misoEn = 1'b1;
         d.misoBit = statusByte[7];
         d.shiftOut = {statusByte[6:0], 17'h00000};
      end else if (q.spiState != LCR_IDLE) begin
         if (sckFall) begin
            // Launch the next bit on the falling edge so it is steady at the rise
            d.misoBit = q.shiftOut[23];
            d.shiftOut = {q.shiftOut[22:0], 1'b0};
         end
         if (sckRise) begin
            d.shiftIn = newWord;
            d.bitCnt = q.bitCnt + 5'h01;
            if (q.bitCnt == lastIdx) begin
               d.bitCnt = 5'h00;
               unique case (q.spiState)
                  LCR_CMD: begin
                     d.regAddr = newWord[`LCR_CMD_REG_HI:`LCR_CMD_REG_LO];
                     d.cmdType = newWord[1:0];
                     if (newWord[`LCR_CMD_DEV_HI:`LCR_CMD_DEV_LO] != `LCR_DEV_ADDR) begin
                        // Another device is addressed: stay silent until deselect
                        d.spiState = LCR_IDLE; // RULE_12
                        d.misoEn = 1'b0;
                     end else if (newWord[1:0] == `LCR_CMD_WRITE) begin
                        d.spiState = LCR_WRITE;
                     end else if (newWord[1:0] == `LCR_CMD_SREAD ||
                                  newWord[1:0] == `LCR_CMD_IREAD) begin
                        d.spiState = LCR_READ;
                        d.shiftOut = readAligned(q, newWord[`LCR_CMD_REG_HI:`LCR_CMD_REG_LO]);
                     end else begin
                        // Fast commands belong to the conversion control logic
                        d.spiState = LCR_IDLE;
                        d.misoEn = 1'b0;
                     end
                  end
                  LCR_WRITE: begin
                     // Locked map: only the key may change, others are dropped quietly
                     if (!locked || q.regAddr == `LCR_ADDR_KEY) begin // RULE_09 RULE_15
                        unique case (q.regAddr)
                           `LCR_ADDR_OFFSET: d.offsetTrim = newWord; // RULE_01
                           `LCR_ADDR_GAIN: d.gainTrim = newWord; // RULE_02
                           `LCR_ADDR_SPARE_B: d.spareWordB = newWord; // RULE_04
                           `LCR_ADDR_SPARE_C: d.spareByteC = newWord[7:0]; // RULE_05
                           `LCR_ADDR_KEY: d.writeKey = newWord[7:0]; // RULE_16
                           `LCR_ADDR_SPARE_E: d.spareHalfwordE = newWord[15:0]; // RULE_06
                           default: d.regAddr = nextAddr; // Checksum and lower map ignored
                        endcase
                     end
                     d.regAddr = nextAddr;
                  end
                  LCR_READ: begin
                     // Static read repeats one register, incremental read walks on
                     if (q.cmdType == `LCR_CMD_IREAD) begin
                        d.regAddr = nextAddr;
                        d.shiftOut = readAligned(q, nextAddr);
                     end else begin
                        d.shiftOut = readAligned(q, q.regAddr);
                     end
                  end
                  default: d.spiState = LCR_IDLE;
               endcase
            end
         end
      end

      // Checksum engine
      if (!locked) begin
         // Unlocked: no computation, value reads zero, compare history forgotten
         d.mapChecksum = `LCR_RST_CHECKSUM; // RULE_08 RULE_16
         d.crcAcc = `LCR_CRC_SEED;
         d.crcIdx = 7'h00;
         d.refValid = 1'b0;
         d.checksumOk = 1'b1;
      end else if (dmRise) begin
         // One configuration bit per modulator clock rising edge; stopped clock holds all
         d.crcAcc = crcNext; // RULE_10
         d.crcIdx = q.crcIdx + 7'h01;
         if (q.crcIdx == `LCR_CFG_LAST) begin
            // Pass complete: publish and restart from the seed
            d.mapChecksum = crcNext; // RULE_11
            d.crcAcc = `LCR_CRC_SEED;
            d.crcIdx = 7'h00;
            d.refValid = 1'b1;
            if (!q.refValid) begin
               // First pass after locking becomes the reference
               d.refChecksum = crcNext;
            end else if (crcNext != q.refChecksum) begin
               // Contents changed under lock: a corrupted configuration bit
               d.checksumOk = 1'b0; // RULE_14
            end
         end
      end

      // Offset code reaches the datapath only while enabled
      d.offsetApplied = offsetCorrectionEnable ? q.offsetTrim : 24'h000000; // RULE_13
   end

   // State register; reset loads the power-on contents
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q <= RESET_STATE; // RULE_01 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_11
      end else begin
         q <= d;
      end
   end

   // Outputs from flip-flops; mapLocked is decoded from the key register
   assign spiMisoOut = q.misoBit;
   assign spiMisoOe = q.misoEn;
   assign offsetCorrectionCode = q.offsetApplied;
   assign gainCorrectionCode = q.gainTrim; // RULE_03
   assign mapLocked = (q.writeKey != `LCR_KEY_UNLOCK);
   assign configChecksumErrorFlag = q.checksumOk; // RULE_14
endmodule

/* File: hdl/lcr_regs_cfg.svh */
// Offsets, field values, reset values and bit counts of the upper register bank
`ifndef LCR_REGS_CFG_SVH
`define LCR_REGS_CFG_SVH

// Register offsets in the serial map
`define LCR_ADDR_OFFSET 4'h9
`define LCR_ADDR_GAIN 4'hA
`define LCR_ADDR_SPARE_B 4'hB
`define LCR_ADDR_SPARE_C 4'hC
`define LCR_ADDR_KEY 4'hD
`define LCR_ADDR_SPARE_E 4'hE
`define LCR_ADDR_CHECKSUM 4'hF

// Reset values
`define LCR_RST_OFFSET 24'h000000
`define LCR_RST_GAIN 24'h800000
`define LCR_RST_SPARE_B 24'h900000
`define LCR_RST_SPARE_C 8'h50
`define LCR_RST_KEY 8'hA5
// Variant value of the 16-bit spare register; the value is arbitrary
`define LCR_RST_SPARE_E 16'h0001
`define LCR_RST_CHECKSUM 16'h0000

// Write key that opens the whole map
`define LCR_KEY_UNLOCK 8'hA5

// Command byte fields and codes
`define LCR_DEV_ADDR 2'h1
`define LCR_CMD_DEV_HI 7
`define LCR_CMD_DEV_LO 6
`define LCR_CMD_REG_HI 5
`define LCR_CMD_REG_LO 2
`define LCR_CMD_SREAD 2'h1
`define LCR_CMD_WRITE 2'h2
`define LCR_CMD_IREAD 2'h3

// Last bit index of each register width, and of the command byte
`define LCR_LAST_24 5'h17
`define LCR_LAST_16 5'h0F
`define LCR_LAST_8 5'h07

// Checksum engine: polynomial, seed and number of configuration bits covered
`define LCR_CRC_POLY 16'h8005
`define LCR_CRC_SEED 16'h0000
`define LCR_CFG_BITS 104
`define LCR_CFG_LAST 7'h67

`endif

/* File: hdl/lcr_regs_pkg.sv */
// Types shared by the upper register bank logic
package lcr_regs_pkg;

   // Serial command phases
   typedef enum logic [1:0] {
      LCR_IDLE = 2'b00,
      LCR_CMD = 2'b01,
      LCR_WRITE = 2'b10,
      LCR_READ = 2'b11
   } lcr_spi_state_t;

   // Whole state of the register bank
   typedef struct packed {
      logic cs1;
      logic cs2;
      logic cs3;
      logic sck1;
      logic sck2;
      logic sck3;
      logic mosi1;
      logic mosi2;
      logic dm1;
      logic dm2;
      logic dm3;
      lcr_spi_state_t spiState;
      logic [1:0] cmdType;
      logic [3:0] regAddr;
      logic [4:0] bitCnt;
      logic [23:0] shiftIn;
      logic [23:0] shiftOut;
      logic misoBit;
      logic misoEn;
      logic [23:0] offsetTrim;
      logic [23:0] gainTrim;
      logic [23:0] spareWordB;
      logic [7:0] spareByteC;
      logic [7:0] writeKey;
      logic [15:0] spareHalfwordE;
      logic [15:0] mapChecksum;
      logic [15:0] crcAcc;
      logic [6:0] crcIdx;
      logic [15:0] refChecksum;
      logic refValid;
      logic checksumOk;
      logic [23:0] offsetApplied;
   } lcr_state_t;

endpackage

/* File: hdl/lcr_crc16_step.sv */
// One serial step of the CRC-16 over the configuration bits
`timescale 1ns/1ps
`include "lcr_regs_cfg.svh"

module lcr_crc16_step (
   // Running remainder and next message bit
   input wire logic [15:0] crcIn,
   input wire logic dataBit,
   // Remainder after the bit
   output logic [15:0] crcOut
);
   logic feedback; // Top bit folded with the message bit

   // Shift left and fold the polynomial in when the feedback is set
   always_comb begin
      feedback = crcIn[15] ^ dataBit;
      crcOut = {crcIn[14:0], 1'b0} ^ (feedback ? `LCR_CRC_POLY : 16'h0000);
   end
endmodule

/* File: tb/lcr_regs_asserts.sv */
// Concurrent checks on the ports of the upper register bank
`timescale 1ns/1ps
module lcr_regs_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Serial port pins
   input wire logic spiCsN,
   input wire logic spiSck,
   input wire logic spiMosi,
   input wire logic spiMisoOut,
   input wire logic spiMisoOe,
   // Side pins and status
   input wire logic modulatorDataClock,
   input wire logic offsetCorrectionEnable,
   input wire logic [23:0] offsetCorrectionCode,
   input wire logic [23:0] gainCorrectionCode,
   input wire logic mapLocked,
   input wire logic configChecksumErrorFlag
);
   // One domain only, so clock and reset are given once
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Locked with the enable held, so the offset output has no cause to move
   sequence lockedWithEnable;
      (mapLocked && offsetCorrectionEnable) [*3];
   endsequence
   // Map open long enough for the error flag to be cleared
   sequence openSpell;
      (!mapLocked) [*3];
   endsequence
   a_reset_defaults: assert property ($fell(reset) |-> gainCorrectionCode == 24'h800000
      && offsetCorrectionCode == 24'h000000 && !mapLocked && configChecksumErrorFlag)
      else $error("wrong values after reset");
   a_oe_answer: assert property ($fell(spiCsN) |-> ##[1:6] spiMisoOe)
      else $error("no answer after select");
   a_oe_release: assert property ($rose(spiCsN) |-> ##[1:6] !spiMisoOe)
      else $error("output kept driven after deselect");
   a_quiet_idle: assert property (spiCsN [*5] |-> !spiMisoOe)
      else $error("output driven while deselected");
   a_offset_gate: assert property (!offsetCorrectionEnable |=> offsetCorrectionCode == 24'h0)
      else $error("offset applied while disabled");
   a_gain_locked: assert property (mapLocked && $past(mapLocked) |-> $stable(gainCorrectionCode))
      else $error("gain moved while locked");
   a_offset_locked: assert property (lockedWithEnable |-> $stable(offsetCorrectionCode))
      else $error("offset moved while locked");
   a_flag_open: assert property (openSpell |-> configChecksumErrorFlag)
      else $error("error flag low while open");
   a_flag_needs_lock: assert property (!configChecksumErrorFlag |-> mapLocked)
      else $error("error flag low on an open map");
endmodule
bind lcr_regs_top lcr_regs_asserts chk_u (
   .clock(clock), .reset(reset), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi),
   .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .modulatorDataClock(modulatorDataClock),
   .offsetCorrectionEnable(offsetCorrectionEnable), .offsetCorrectionCode(offsetCorrectionCode),
   .gainCorrectionCode(gainCorrectionCode), .mapLocked(mapLocked),
   .configChecksumErrorFlag(configChecksumErrorFlag)
);

/* File: tb/lcr_spi_host.sv */
// Serial host model that configures the register bank over its pins
`timescale 1ns/1ps
`include "lcr_regs_cfg.svh"
module lcr_spi_host (
   // Clock that paces the serial bits
   input wire logic clock,
   // Serial pins
   output logic spiCsN,
   output logic spiSck,
   output logic spiMosi,
   input wire logic spiMisoOut,
   input wire logic spiMisoOe
);
   // Released line shows the inverse, so a stale bit never passes for data
   logic misoLine;
   assign misoLine = spiMisoOe ? spiMisoOut : ~spiMisoOut;
   initial begin
      spiCsN = 1'b1;
      spiSck = 1'b0;
      spiMosi = 1'b0;
   end
   // Wait n clocks, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Command byte always carries the device address
   function automatic logic [7:0] cmdByte(input logic [3:0] regA, input logic [1:0] kind);
      return {`LCR_DEV_ADDR, regA, kind};
   endfunction
   // One frame: command, then nbits of data MSB first; phases last 5 clocks to meet sync
   task automatic xfer(input logic [7:0] cmd, input logic [127:0] wdata, input int nbits,
      output logic [127:0] rdata);
      logic [135:0] frame;
      frame = {cmd, 128'h0} | ({8'h00, wdata} << (128 - nbits));
      rdata = '0;
      spiCsN = 1'b0;
      tick(5);
      for (int i = 0; i < 8 + nbits; i++) begin
         spiMosi = frame[135 - i];
         tick(5);
         spiSck = 1'b1;
         // Mode 0: the bit is taken at the rising edge
         if (i >= 8) begin
            rdata = {rdata[126:0], misoLine};
         end
         tick(5);
         spiSck = 1'b0;
      end
      tick(5);
      spiCsN = 1'b1;
      spiMosi = ~spiMosi;
      tick(8);
   endtask
endmodule

/* File: tb/lcr_regs_top_tb.sv */
// Self-checking bench of the upper register bank
`timescale 1ns/1ps
`include "lcr_regs_cfg.svh"
module lcr_regs_top_tb;
   import lcr_regs_pkg::*;
   // Clock, reset and side inputs
   logic clock;
   logic reset;
   logic modulatorDataClock;
   logic offsetCorrectionEnable;
   // Serial pins and outputs
   logic spiCsN, spiSck, spiMosi, spiMisoOut, spiMisoOe, mapLocked, configChecksumErrorFlag;
   logic [23:0] offsetCorrectionCode;
   logic [23:0] gainCorrectionCode;
   logic [127:0] rd;
   int n_mismatch = 0;
   int checked = 0;
   lcr_regs_top dut_u (.clock(clock), .reset(reset), .spiCsN(spiCsN), .spiSck(spiSck),
      .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe),
      .modulatorDataClock(modulatorDataClock), .offsetCorrectionEnable(offsetCorrectionEnable),
      .offsetCorrectionCode(offsetCorrectionCode), .gainCorrectionCode(gainCorrectionCode),
      .mapLocked(mapLocked), .configChecksumErrorFlag(configChecksumErrorFlag));
   lcr_spi_host hostU (.clock(clock), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi),
      .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe));
   // Compare one value, four-state exact
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h", $time, what, got);
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Independent CRC-16, poly 8005, zero seed, MSB first
   function automatic logic [15:0] crcOf(input logic [103:0] cfg);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 103; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ cfg[i]) ? 16'h8005 : 16'h0000);
      end
      return c;
   endfunction
   // Modulator clock pulses, kept slow against the input synchronizer
   task automatic mdEdges(input int n);
      repeat (n) begin
         modulatorDataClock = 1'b1;
         hostU.tick(4);
         modulatorDataClock = 1'b0;
         hostU.tick(4);
      end
   endtask
   // Whole upper map in one incremental read, plus an unmapped address
   task automatic t_defaults();
      hostU.xfer(hostU.cmdByte(4'h9, `LCR_CMD_IREAD), 128'h0, 120, rd);
      chk(rd, {24'h000000, 24'h800000, 24'h900000, 8'h50, 8'hA5, `LCR_RST_SPARE_E, 16'h0000},
         "reset map");
      hostU.xfer(hostU.cmdByte(4'h3, `LCR_CMD_SREAD), 128'h0, 8, rd);
      chk(rd, 128'h0, "unmapped read");
      chk(128'(gainCorrectionCode), 128'h800000, "gain output");
   endtask
   // Open map: write 9..C, read back, offset gating, read-only checksum
   task automatic t_open_write();
      hostU.xfer(hostU.cmdByte(4'h9, `LCR_CMD_WRITE),
         {24'hFEDCBA, 24'h7FFFFF, 24'h900000, 8'h50}, 80, rd);
      hostU.xfer(hostU.cmdByte(4'h9, `LCR_CMD_IREAD), 128'h0, 80, rd);
      chk(rd, {24'hFEDCBA, 24'h7FFFFF, 24'h900000, 8'h50}, "readback");
      chk(128'(gainCorrectionCode), 128'h7FFFFF, "gain output");
      chk(128'(offsetCorrectionCode), 128'h0, "offset while disabled");
      offsetCorrectionEnable = 1'b1;
      hostU.tick(2);
      chk(128'(offsetCorrectionCode), 128'hFEDCBA, "offset enabled");
      hostU.xfer(hostU.cmdByte(4'hF, `LCR_CMD_WRITE), 128'h1234, 16, rd);
      hostU.xfer(hostU.cmdByte(4'hF, `LCR_CMD_SREAD), 128'h0, 16, rd);
      chk(rd, 128'h0, "checksum written");
   endtask
   // Command for another device address must change nothing
   task automatic t_bad_address();
      hostU.xfer({2'h2, 4'h9, `LCR_CMD_WRITE}, 128'h000111, 24, rd);
      hostU.xfer(hostU.cmdByte(4'h9, `LCR_CMD_SREAD), 128'h0, 24, rd);
      chk(rd, 128'hFEDCBA, "foreign address");
   endtask
   // Lock, refused write, checksum over two passes
   task automatic t_locked();
      hostU.xfer(hostU.cmdByte(4'hD, `LCR_CMD_WRITE), 128'h3C, 8, rd);
      chk(128'(mapLocked), 128'h1, "locked status");
      hostU.xfer(hostU.cmdByte(4'hA, `LCR_CMD_WRITE), 128'h000001, 24, rd);
      hostU.xfer(hostU.cmdByte(4'hA, `LCR_CMD_SREAD), 128'h0, 24, rd);
      chk(rd, 128'h7FFFFF, "locked write");
      mdEdges(212);
      hostU.xfer(hostU.cmdByte(4'hF, `LCR_CMD_SREAD), 128'h0, 16, rd);
      chk(rd, 128'(crcOf({24'hFEDCBA, 24'h7FFFFF, 24'h900000, 8'h50, 8'h3C, `LCR_RST_SPARE_E})),
         "checksum");
      chk(128'(configChecksumErrorFlag), 128'h1, "error flag");
   endtask
   // Key back to open: checksum cleared, writes accepted again
   task automatic t_unlock();
      hostU.xfer(hostU.cmdByte(4'hD, `LCR_CMD_WRITE), 128'hA5, 8, rd);
      chk(128'(mapLocked), 128'h0, "open status");
      hostU.xfer(hostU.cmdByte(4'hF, `LCR_CMD_SREAD), 128'h0, 16, rd);
      chk(rd, 128'h0, "checksum when open");
      hostU.xfer(hostU.cmdByte(4'hA, `LCR_CMD_WRITE), 128'h800000, 24, rd);
      chk(128'(gainCorrectionCode), 128'h800000, "gain rewritten");
   endtask
   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      modulatorDataClock = 1'b0;
      offsetCorrectionEnable = 1'b0;
      hostU.tick(20);
      reset = 1'b0;
      hostU.tick(4);
      t_defaults();
      t_open_write();
      t_bad_address();
      t_locked();
      t_unlock();
      test_done();
   end
   // Hang guard, well above the length of a normal run
   initial begin
      #900000;
      n_mismatch++;
      test_done();
   end
endmodule
